// ===== rtl/dsp_slice_regs.vh
// Register offsets, field positions, reset values and widths of the
// multiply-accumulate slice.
// Assumes inclusion by bare name from the slice design files.
`ifndef DSP_SLICE_REGS_VH
`define DSP_SLICE_REGS_VH

// ****************************************************************
// Register offsets (byte addresses, one word each).
// ****************************************************************
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_IRQ_MASK      8'h08
`define REG_RESULT_LO     8'h0C
`define REG_RESULT_HI     8'h10

// ****************************************************************
// Control register fields.
// ****************************************************************
`define CTRL_MODE_LSB     0
`define CTRL_MODE_MSB     1
`define CTRL_WIDTH_LSB    2
`define CTRL_WIDTH_MSB    3
`define CTRL_IN_REG       4
`define CTRL_PIPE_REG     5
`define CTRL_OUT_REG      6
`define CTRL_DYN          7
`define CTRL_SUB          8
`define CTRL_SHIFT        9
`define CTRL_BITS         10
`define CTRL_RESET        10'h070

// ****************************************************************
// Mode and width encodings.
// ****************************************************************
`define MODE_PLAIN        2'h0
`define MODE_ACCUM        2'h1
`define MODE_ADDSUB       2'h2
`define MODE_TOTAL        2'h3
`define WIDTH_X9          2'h0
`define WIDTH_X18         2'h1
`define WIDTH_X36         2'h2

// ****************************************************************
// Status and mask bits.
// ****************************************************************
`define ST_OVERFLOW       0
`define ST_INIT           1
`define ST_BITS           2
`define ST_RESET          2'h0

// ****************************************************************
// Datapath widths.
// ****************************************************************
`define OP_W              18
`define HALF_W            9
`define ACC_W             54
`define PROD_W            72

`endif

// ===== rtl/dsp_operand_reg.v
// One operand input register with parallel or shifted load and bypass.
// Assumes operands come from logic on the same clock.
`timescale 1ns/1ns
`include "dsp_slice_regs.vh"

module dsp_operand_reg (
    // Clock and control
    input  wire                clk_sys,
    input  wire                rst_n,
    input  wire                ce,
    // Load selection
    input  wire                sel_shift,
    input  wire                reg_en,
    // Data
    input  wire [`OP_W-1:0]    par_in,
    input  wire [`OP_W-1:0]    shift_in,
    output wire [`OP_W-1:0]    held,
    output wire [`OP_W-1:0]    op_out
);

    reg  [`OP_W-1:0] op_q;
    wire [`OP_W-1:0] op_d;

    assign op_d = sel_shift ? shift_in : par_in;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            op_q <= {`OP_W{1'b0}};
        end else if (ce) begin
            op_q <= op_d;
        end
    end

    // With the register bypassed the selected load passes straight through.
    assign held   = op_q;
    assign op_out = reg_en ? op_q : op_d;

endmodule

// ===== rtl/dsp_mac_slice.v
// Multiply slice: plain products, accumulate, dual-product add/subtract
// and add/subtract with cascade total, plus its register port.
// Assumes operands and controls come from fabric logic on clk_sys.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "dsp_slice_regs.vh"

module dsp_mac_slice (
    // Clock, reset and enable
    input  wire                 clk_sys,
    input  wire                 rst_n,
    input  wire                 ce,
    // Register port
    input  wire [7:0]           reg_addr,
    input  wire [31:0]          reg_wdata,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    output reg  [31:0]          reg_rdata,
    output wire                 irq,
    // Operands
    input  wire [`OP_W-1:0]     first_pair_operand_x,
    input  wire [`OP_W-1:0]     first_pair_operand_y,
    input  wire [`OP_W-1:0]     second_pair_operand_x,
    input  wire [`OP_W-1:0]     second_pair_operand_y,
    // Shift chain
    input  wire [`OP_W-1:0]     shift_in_x,
    input  wire [`OP_W-1:0]     shift_in_y,
    output wire [`OP_W-1:0]     shift_out_x,
    output wire [`OP_W-1:0]     shift_out_y,
    // Dynamic controls
    input  wire                 dyn_subtract,
    input  wire                 dyn_shift_load,
    input  wire                 acc_load,
    input  wire [`ACC_W-1:0]    acc_init_value,
    // Cascade path
    input  wire [`ACC_W-1:0]    cascade_in,
    output wire [`ACC_W-1:0]    cascade_out,
    // Results
    output wire [`PROD_W-1:0]   plain_product,
    output wire [`ACC_W-1:0]    result,
    output wire                 overflow
);

    // ****************************************************************
    // Arithmetic helpers.
    // ****************************************************************
    function [2*`HALF_W-1:0] mul9;
        input [`HALF_W-1:0] a;
        input [`HALF_W-1:0] b;
        begin
            mul9 = $signed(a) * $signed(b);
        end
    endfunction

    function [2*`OP_W-1:0] mul18;
        input [`OP_W-1:0] a;
        input [`OP_W-1:0] b;
        begin
            mul18 = $signed(a) * $signed(b);
        end
    endfunction

    function [`ACC_W-1:0] sx18;
        input [2*`HALF_W-1:0] v;
        begin
            sx18 = {{(`ACC_W-2*`HALF_W){v[2*`HALF_W-1]}}, v};
        end
    endfunction

    function [`ACC_W-1:0] sx36;
        input [2*`OP_W-1:0] v;
        begin
            sx36 = {{(`ACC_W-2*`OP_W){v[2*`OP_W-1]}}, v};
        end
    endfunction

    function [`ACC_W-1:0] add_sub;
        input [`ACC_W-1:0] a;
        input [`ACC_W-1:0] b;
        input              sub;
        begin
            add_sub = sub ? a - b : a + b;
        end
    endfunction

    // ****************************************************************
    // Control and status registers.
    // ****************************************************************
    reg  [`CTRL_BITS-1:0] ctrl_q;
    reg  [`ST_BITS-1:0]   status_q;
    reg  [`ST_BITS-1:0]   mask_q;
    reg  [`ST_BITS-1:0]   status_set;
    reg  [`ACC_W-1:0]     res_q;
    reg                   ovf_q;

    wire [1:0] mode      = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    wire [1:0] width     = ctrl_q[`CTRL_WIDTH_MSB:`CTRL_WIDTH_LSB];
    wire       in_reg_en = ctrl_q[`CTRL_IN_REG];
    wire       pipe_en   = ctrl_q[`CTRL_PIPE_REG];
    wire       dyn_en    = ctrl_q[`CTRL_DYN];
    wire       is_accum  = (mode == `MODE_ACCUM);
    wire       out_en    = ctrl_q[`CTRL_OUT_REG] | is_accum;

    wire       subtract   = dyn_en ? dyn_subtract : ctrl_q[`CTRL_SUB];
    wire       shift_load = dyn_en ? dyn_shift_load : ctrl_q[`CTRL_SHIFT];

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_q <= `CTRL_RESET;
            mask_q <= `ST_RESET;
        end else if (ce && reg_wr) begin
            if (reg_addr == `REG_CTRL) begin
                ctrl_q <= reg_wdata[`CTRL_BITS-1:0];
            end else if (reg_addr == `REG_IRQ_MASK) begin
                mask_q <= reg_wdata[`ST_BITS-1:0];
            end
        end
    end

    // A read clears the status word, but a new event in the same cycle stays set.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            status_q <= `ST_RESET;
        end else if (ce) begin
            if (reg_rd && reg_addr == `REG_STATUS) begin
                status_q <= status_set;
            end else begin
                status_q <= status_q | status_set;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (ce) begin
            if (!reg_rd) begin
                reg_rdata <= 32'h0000_0000;
            end else if (reg_addr == `REG_CTRL) begin
                reg_rdata <= {{(32-`CTRL_BITS){1'b0}}, ctrl_q};
            end else if (reg_addr == `REG_STATUS) begin
                reg_rdata <= {{(32-`ST_BITS){1'b0}}, status_q};
            end else if (reg_addr == `REG_IRQ_MASK) begin
                reg_rdata <= {{(32-`ST_BITS){1'b0}}, mask_q};
            end else if (reg_addr == `REG_RESULT_LO) begin
                reg_rdata <= res_q[31:0];
            end else if (reg_addr == `REG_RESULT_HI) begin
                reg_rdata <= {ovf_q, {(63-`ACC_W){1'b0}}, res_q[`ACC_W-1:32]};
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end
    end

    assign irq = |(status_q & mask_q);

    // ****************************************************************
    // Input registers and shift chain.
    // ****************************************************************
    wire [`OP_W-1:0] fx_out;
    wire [`OP_W-1:0] fy_out;
    wire [`OP_W-1:0] sx_out;
    wire [`OP_W-1:0] sy_out;
    wire [`OP_W-1:0] fx_held;
    wire [`OP_W-1:0] fy_held;

    // The first pair shifts in from the preceding slice, the second from the first.
    dsp_operand_reg u_first_x (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .ce        (ce),
        .sel_shift (shift_load),
        .reg_en    (in_reg_en),
        .par_in    (first_pair_operand_x),
        .shift_in  (shift_in_x),
        .held      (fx_held),
        .op_out    (fx_out)
    );

    dsp_operand_reg u_first_y (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .ce        (ce),
        .sel_shift (shift_load),
        .reg_en    (in_reg_en),
        .par_in    (first_pair_operand_y),
        .shift_in  (shift_in_y),
        .held      (fy_held),
        .op_out    (fy_out)
    );

    dsp_operand_reg u_second_x (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .ce        (ce),
        .sel_shift (shift_load),
        .reg_en    (in_reg_en),
        .par_in    (second_pair_operand_x),
        .shift_in  (fx_held),
        .held      (shift_out_x),
        .op_out    (sx_out)
    );

    dsp_operand_reg u_second_y (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .ce        (ce),
        .sel_shift (shift_load),
        .reg_en    (in_reg_en),
        .par_in    (second_pair_operand_y),
        .shift_in  (fy_held),
        .held      (shift_out_y),
        .op_out    (sy_out)
    );

    // ****************************************************************
    // Multipliers and pipeline register.
    // ****************************************************************
    wire [`PROD_W-1:0] prod_x9;
    wire [`PROD_W-1:0] prod_x18;
    wire [`PROD_W-1:0] prod_c;
    reg  [`PROD_W-1:0] prod_q;
    wire [`PROD_W-1:0] prod_s;

    // Narrow mode keeps four 9x9 products in 18-bit lanes, wide mode two 18x18.
    assign prod_x9  = {mul9(sx_out[17:9], sy_out[17:9]), mul9(sx_out[8:0], sy_out[8:0]),
                       mul9(fx_out[17:9], fy_out[17:9]), mul9(fx_out[8:0], fy_out[8:0])};
    assign prod_x18 = {mul18(sx_out, sy_out), mul18(fx_out, fy_out)};
    assign prod_c   = (width == `WIDTH_X9) ? prod_x9 : prod_x18;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            prod_q <= {`PROD_W{1'b0}};
        end else if (ce) begin
            prod_q <= prod_c;
        end
    end

    assign prod_s = pipe_en ? prod_q : prod_c;

    // ****************************************************************
    // Adders.
    // ****************************************************************
    wire [`ACC_W-1:0] term_a;
    wire [`ACC_W-1:0] term_b;
    wire [`ACC_W-1:0] pair_sum;
    wire [26:0]       hi_lane;
    wire [`ACC_W-1:0] wide_part;
    wire [`ACC_W:0]   acc_ext;

    // In 36-bit mode the two products form one half of the split multiply.
    assign wide_part = sx36(prod_s[35:0]) + {prod_s[71:36], 18'h0_0000};

    assign term_a = (width == `WIDTH_X9)  ? sx18(prod_s[17:0]) :
                    (width == `WIDTH_X36) ? wide_part : sx36(prod_s[35:0]);
    assign term_b = (width == `WIDTH_X9)  ? sx18(prod_s[53:36]) : sx36(prod_s[71:36]);

    assign pair_sum = add_sub(term_a, term_b, subtract);
    assign hi_lane  = subtract ? {{9{prod_s[35]}}, prod_s[35:18]} - {{9{prod_s[71]}}, prod_s[71:54]}
                               : {{9{prod_s[35]}}, prod_s[35:18]} + {{9{prod_s[71]}}, prod_s[71:54]};

    // One extra bit exposes a signed overflow of the wrapping accumulator.
    assign acc_ext = subtract ? {res_q[`ACC_W-1], res_q} - {term_a[`ACC_W-1], term_a}
                     : {res_q[`ACC_W-1], res_q} + {term_a[`ACC_W-1], term_a};

    assign cascade_out = pair_sum;

    // ****************************************************************
    // Result selection and output register.
    // ****************************************************************
    reg  [`ACC_W-1:0]  res_d;
    reg                ovf_d;
    reg  [`PROD_W-1:0] prod_out_q;

    always @* begin
        res_d = term_a;
        ovf_d = 1'b0;
        case (mode)
            `MODE_PLAIN: begin
                res_d = (width == `WIDTH_X36) ? term_a + cascade_in : term_a;
            end
            `MODE_ACCUM: begin
                if (acc_load) begin
                    res_d = acc_init_value;
                end else begin
                    res_d = acc_ext[`ACC_W-1:0];
                    ovf_d = acc_ext[`ACC_W] ^ acc_ext[`ACC_W-1];
                end
            end
            `MODE_ADDSUB: begin
                res_d = (width == `WIDTH_X9) ? {hi_lane, pair_sum[26:0]} : pair_sum;
            end
            default: begin
                res_d = pair_sum + cascade_in;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            res_q      <= {`ACC_W{1'b0}};
            ovf_q      <= 1'b0;
            prod_out_q <= {`PROD_W{1'b0}};
        end else if (ce) begin
            res_q      <= res_d;
            ovf_q      <= ovf_d;
            prod_out_q <= prod_s;
        end
    end

    always @* begin
        status_set                = {`ST_BITS{1'b0}};
        status_set[`ST_OVERFLOW]  = ovf_d;
        status_set[`ST_INIT]      = is_accum & acc_load;
    end

    assign result        = out_en ? res_q : res_d;
    assign plain_product = ctrl_q[`CTRL_OUT_REG] ? prod_out_q : prod_s;
    assign overflow      = ovf_q;

endmodule

// ===== bench/dsp_slice_checker_sva.sv
// Port-level assertions for the multiply-accumulate slice.
// Assumes it is bound to every instance of the slice.
`timescale 1ns/1ns
`include "dsp_slice_regs.vh"

module dsp_slice_checker (
    // Clock and control
    input wire               clk_sys,
    input wire               rst_n,
    input wire               ce,
    // Register port
    input wire [7:0]         reg_addr,
    input wire               reg_wr,
    input wire               reg_rd,
    input wire [31:0]        reg_rdata,
    input wire               irq,
    // Datapath
    input wire               acc_load,
    input wire [`OP_W-1:0]   shift_out_x,
    input wire [`OP_W-1:0]   shift_out_y,
    input wire [`ACC_W-1:0]  result,
    input wire               overflow
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    reset_clear_a: assert property (disable iff (1'b0) (!rst_n && ce) |=>
        (reg_rdata == 32'h0000_0000) && !irq && !overflow && (result == 54'h0))
        else $error("outputs not cleared by reset");
    rdata_idle_a: assert property ((ce && !reg_rd) |=> (reg_rdata == 32'h0000_0000))
        else $error("read data not zero outside a read");
    ce_freeze_a: assert property (!ce |=> $stable(overflow) && $stable(reg_rdata)
        && $stable(shift_out_x) && $stable(shift_out_y))
        else $error("state moved with enable low");
    ovf_total_a: assert property ($rose(overflow) |-> !$stable(result))
        else $error("overflow rose without a new total");
    unmapped_read_a: assert property ((ce && reg_rd && reg_addr > `REG_RESULT_HI) |=>
        (reg_rdata == 32'h0000_0000))
        else $error("unmapped read returned data");
    hi_word_a: assert property ((ce && reg_rd && reg_addr == `REG_RESULT_HI) |=>
        (reg_rdata[31] == $past(overflow)) && (reg_rdata[30:22] == 9'h000))
        else $error("upper result word wrong");
    irq_fall_a: assert property ($fell(irq) |-> $past(reg_rd || reg_wr) || !$past(rst_n))
        else $error("interrupt dropped without an access");
    irq_rise_a: assert property ($rose(irq) |-> $past(reg_wr || acc_load) || overflow)
        else $error("interrupt rose without an event");
    load_no_ovf_a: assert property ((ce && acc_load) |=> !overflow)
        else $error("overflow flagged on a load");
endmodule

bind dsp_mac_slice dsp_slice_checker u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .acc_load(acc_load),
    .shift_out_x(shift_out_x), .shift_out_y(shift_out_y), .result(result),
    .overflow(overflow));

// ===== bench/fabric_neighbour.sv
// Model of the preceding slice: operand chain source and cascade partial.
// Assumes the same clock, enable and reset as the slice under test.
`timescale 1ns/1ns
`include "dsp_slice_regs.vh"

module fabric_neighbour (
    // Clock and control
    input  wire               clk_sys,
    input  wire               rst_n,
    input  wire               ce,
    // Operands from fabric
    input  wire [`OP_W-1:0]   op_x,
    input  wire [`OP_W-1:0]   op_y,
    // Chain and cascade
    output logic [`OP_W-1:0]  shift_x,
    output logic [`OP_W-1:0]  shift_y,
    output wire [`ACC_W-1:0]  partial
);
    always @(posedge clk_sys) begin
        if (ce && !rst_n) begin
            shift_x <= 18'h0_0000;
            shift_y <= 18'h0_0000;
        end else if (ce) begin
            shift_x <= op_x;
            shift_y <= op_y;
        end
    end

    assign partial = $signed(shift_x) * $signed(shift_y);
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the multiply-accumulate slice.
// Assumes the slice, its checker and the neighbour model compile first.
`timescale 1ns/1ns
`include "dsp_slice_regs.vh"

module tb_top;
    logic        clk_sys, rst_n, ce, reg_wr, reg_rd, dsub, dshift, aload;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, rd;
    logic [17:0] fx, fy, sx, sy, nx, ny;
    logic [53:0] init;
    wire  [31:0] reg_rdata;
    wire  [17:0] shx, shy, sox, soy;
    wire  [53:0] part, casc, res;
    wire  [71:0] prod;
    wire         irq, ovf;
    int          mismatches, compares;

    dsp_mac_slice DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .first_pair_operand_x(fx), .first_pair_operand_y(fy),
        .second_pair_operand_x(sx), .second_pair_operand_y(sy), .shift_in_x(shx),
        .shift_in_y(shy), .shift_out_x(sox), .shift_out_y(soy), .dyn_subtract(dsub),
        .dyn_shift_load(dshift), .acc_load(aload), .acc_init_value(init),
        .cascade_in(part), .cascade_out(casc), .plain_product(prod), .result(res),
        .overflow(ovf));
    fabric_neighbour u_nbr (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .op_x(nx),
        .op_y(ny), .shift_x(shx), .shift_y(shy), .partial(part));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    function automatic logic [53:0] mul(input logic [17:0] a, input logic [17:0] b);
        logic signed [53:0] p;
        p = $signed(a) * $signed(b);
        return p;
    endfunction
    function automatic logic [17:0] m9(input logic [8:0] a, input logic [8:0] b);
        logic signed [17:0] p;
        p = $signed(a) * $signed(b);
        return p;
    endfunction

    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Presents operands for exactly one sampling edge, then idles them at zero.
    task automatic op(input logic [17:0] a, b, input logic ld, sb, sh);
        @(posedge clk_sys);
        fx <= a;
        fy <= b;
        aload <= ld;
        dsub <= sb;
        dshift <= sh;
        @(posedge clk_sys);
        fx <= 18'h0_0000;
        fy <= 18'h0_0000;
        aload <= 1'b0;
        dsub <= 1'b0;
        #1;
    endtask

    task automatic t_reset;
        rd_reg(`REG_CTRL, rd);
        chk(rd, 32'h0000_0070);
        rd_reg(`REG_STATUS, rd);
        chk(rd, 32'h0000_0000);
        rd_reg(`REG_IRQ_MASK, rd);
        chk(rd, 32'h0000_0000);
        rd_reg(8'h14, rd);
        chk(rd, 32'h0000_0000);
        chk(res, 54'h0);
    endtask
    task automatic t_plain;
        wr(`REG_CTRL, 32'h0000_0004);
        fx <= 18'h3_FFFD;
        fy <= 18'h0_0005;
        sx <= 18'h2_0107;
        sy <= 18'h1_FF02;
        @(posedge clk_sys);
        #1 chk(prod, {36'(mul(sx, sy)), 36'(mul(fx, fy))});
        wr(`REG_CTRL, 32'h0000_0000);
        @(posedge clk_sys);
        #1 chk(prod, {m9(sx[17:9], sy[17:9]), m9(sx[8:0], sy[8:0]),
            m9(fx[17:9], fy[17:9]), m9(fx[8:0], fy[8:0])});
    endtask
    task automatic t_pairs;
        logic [53:0] e;
        for (int m = 2; m < 4; m++) begin
            for (int s = 0; s < 2; s++) begin
                wr(`REG_CTRL, 32'h0000_0004 | m | (s << 8));
                @(posedge clk_sys);
                #1 e = s ? mul(fx, fy) - mul(sx, sy) : mul(fx, fy) + mul(sx, sy);
                chk(casc, e);
                if (m == 3) e = e + part;
                chk(res, e);
            end
        end
    endtask
    task automatic t_shift;
        wr(`REG_CTRL, 32'h0000_0094);
        op(18'h0_0011, 18'h0_0003, 1'b0, 1'b0, 1'b1);
        chk(prod[35:0], 36'(mul(nx, ny)));
        @(posedge clk_sys);
        #1 chk(sox, nx);
        chk(soy, ny);
        op(18'h0_0011, 18'h0_0003, 1'b0, 1'b0, 1'b0);
        chk(prod[35:0], 36'h0_0000_0033);
        chk(sox, sx);
        chk(soy, sy);
        // Static shifted load: the first pair takes the neighbour's operands.
        wr(`REG_CTRL, 32'h0000_0214);
        @(posedge clk_sys);
        #1 chk(prod[35:0], 36'(mul(nx, ny)));
    endtask
    // Split multiply with input, pipeline and output registers all enabled.
    task automatic t_wide;
        logic [53:0] e;
        wr(`REG_CTRL, 32'h0000_0078);
        fx <= 18'h0_0123;
        fy <= 18'h3_FF00;
        sx <= 18'h0_0002;
        sy <= 18'h3_FFFD;
        repeat (2) @(posedge clk_sys);
        #1 chk(prod, 72'h0);
        chk(res, part);
        @(posedge clk_sys);
        #1 chk(prod, {36'(mul(sx, sy)), 36'(mul(fx, fy))});
        e = mul(fx, fy) + (mul(sx, sy) << 18) + part;
        chk(res, e);
    endtask
    task automatic t_accum;
        logic [53:0] e;
        wr(`REG_CTRL, 32'h0000_00C5);
        init <= 54'h00_0000_0000_0064;
        op(18'h0_0000, 18'h0_0000, 1'b1, 1'b0, 1'b0);
        e = 54'h00_0000_0000_0064;
        chk(res, e);
        for (int s = 0; s < 2; s++) begin
            op(18'h0_0003, 18'h3_FFFC, 1'b0, s[0], 1'b0);
            e = s ? e - mul(18'h0_0003, 18'h3_FFFC) : e + mul(18'h0_0003, 18'h3_FFFC);
            chk(res, e);
        end
        wr(`REG_CTRL, 32'h0000_0145);
        op(18'h0_0005, 18'h0_0002, 1'b0, 1'b0, 1'b0);
        e = e - 54'h00_0000_0000_000A;
        chk(res, e);
        @(posedge clk_sys);
        ce <= 1'b0;
        fx <= 18'h0_0007;
        fy <= 18'h0_0007;
        repeat (2) @(posedge clk_sys);
        ce <= 1'b1;
        fx <= 18'h0_0000;
        fy <= 18'h0_0000;
        init <= 54'h1F_FFFF_FFFF_FFFF;
        #1 chk(res, e);
        op(18'h0_0000, 18'h0_0000, 1'b1, 1'b0, 1'b0);
        chk(res, 54'h1F_FFFF_FFFF_FFFF);
        op(18'h3_FFFF, 18'h0_0001, 1'b0, 1'b0, 1'b0);
        chk(res, 54'h20_0000_0000_0000);
        chk(ovf, 1'b1);
        @(posedge clk_sys);
        #1 chk(ovf, 1'b0);
        chk(irq, 1'b0);
        wr(`REG_IRQ_MASK, 32'h0000_0001);
        #1 chk(irq, 1'b1);
        rd_reg(`REG_STATUS, rd);
        chk(rd, 32'h0000_0003);
        chk(irq, 1'b0);
        rd_reg(`REG_RESULT_HI, rd);
        chk(rd, 32'h0020_0000);
    endtask

    initial begin
        #100000;
        mismatches++;
        end_sim;
    end

    initial begin
        {rst_n, reg_wr, reg_rd, dsub, dshift, aload} = 6'h00;
        ce = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        {fx, fy, sx, sy} = 72'h0;
        nx = 18'h0_0009;
        ny = 18'h3_FFFF;
        init = 54'h0;
        mismatches = 0;
        compares = 0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_wide;
        t_plain;
        t_pairs;
        t_shift;
        t_accum;
        end_sim;
    end
endmodule
